// ---- common/frt_pkg.sv ----
/*
  Constants, field layouts and carrier types for the 16-bit free-running
  timer with compare, capture and coherent counter readout.
  Assumes a byte-wide CPU port with one clock and a synchronous reset.
*/
package frt_pkg;

  // ----------------------------------------------------------------
  // Byte addresses on the CPU port
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CNT_LO = 16'hff12;
  localparam logic [15:0] ADDR_CNT_HI = 16'hff13;
  localparam logic [15:0] ADDR_CAP_LO = 16'hff14;
  localparam logic [15:0] ADDR_CAP_HI = 16'hff15;
  localparam logic [15:0] ADDR_CMP_LO = 16'hff16;
  localparam logic [15:0] ADDR_CMP_HI = 16'hff17;
  localparam logic [15:0] ADDR_MODE   = 16'hff48;

  // ----------------------------------------------------------------
  // Reset values and counter top
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [15:0] CMP_RESET  = 16'hffff;
  localparam logic [15:0] CAP_RESET  = 16'h0000;
  localparam logic [7:0]  MODE_RESET = 8'h00;
  localparam logic [15:0] CNT_TOP    = 16'hffff;

  // ----------------------------------------------------------------
  // Timing: count clock prescaler and interrupt window
  // ----------------------------------------------------------------
  localparam int          DIV_RATIO  = 32;
  localparam logic [4:0]  DIV_LAST   = 5'(DIV_RATIO - 1);
  localparam logic [4:0]  HALF_DIV   = 5'(DIV_RATIO / 2);
  localparam logic [4:0]  HALF_FAST  = 5'h01;

  // Count clock select codes
  typedef enum logic [1:0] {
    CLK_DIRECT = 2'b00,
    CLK_DIV32  = 2'b01
  } clk_sel_t;

  // Capture edge select codes
  typedef enum logic [1:0] {
    EDGE_OFF  = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_t;

  // Mode control register, bit 7 down to bit 0
  typedef struct packed {
    logic       output_level;
    logic       overflow_flag;
    logic [1:0] edge_sel;
    logic       toggle_enable;
    logic [1:0] clk_sel;
    logic       output_enable;
  } timer_mode_ctrl_t;

  // One CPU byte access
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } cpu_req_t;

endpackage

// ---- rtl/free_running_timer.sv ----
/*
  16-bit free-running timer: counter, compare match interrupt and output
  toggle, pin capture, and a read buffer that keeps counter byte reads coherent.
  Assumes capture_pin_i and the CPU strobes are synchronous to clk_i.
*/
`timescale 1ns/1ns
module free_running_timer (
  input  wire logic              clk_i,            // 125 MHz main clock
  input  wire logic              reset_n_i,        // Synchronous reset, active low
  input  wire frt_pkg::cpu_req_t cpu_req_i,        // CPU byte access
  output logic [7:0]             rdata_o,          // Read data, registered
  input  wire logic              capture_pin_i,    // Capture trigger pin
  output logic                   timer_out_o,      // Timer output level
  output logic                   timer_out_oe_n_o, // Output enable, low drives
  output logic                   match_irq_o       // Compare match interrupt
);
  import frt_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0]      cnt_ff,  nxt_cnt;
  logic [15:0]      cmp_ff,  nxt_cmp;
  logic [15:0]      cap_ff,  nxt_cap;
  logic [15:0]      buf_ff,  nxt_buf;
  timer_mode_ctrl_t mode_ff, nxt_mode;
  logic [4:0]       div_ff,  nxt_div;
  logic [4:0]       win_ff,  nxt_win;
  logic             frozen_ff, nxt_frozen;
  logic             pin_ff,  nxt_pin;
  logic             lo_ff,   nxt_lo;
  logic             hi_ff,   nxt_hi;
  logic [7:0]       rdata_ff, nxt_rdata;

  logic tick, match, cap_edge, lo_rd, hi_rd, lo_rise, hi_fall, toggle_rise, wrap;

  // Address match for one byte strobe
  function automatic logic hit(input cpu_req_t r, input logic [15:0] a);
    return r.addr == a;
  endfunction

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  // Codes 10 and 11 also run on the divided clock; they are prohibited anyway
  assign tick    = (mode_ff.clk_sel == CLK_DIRECT) || (div_ff == DIV_LAST);
  // A compare write just behind the current count waits a full wrap
  assign match   = tick && (cnt_ff == cmp_ff);
  assign wrap    = tick && (cnt_ff == CNT_TOP);
  assign lo_rd   = cpu_req_i.rd && hit(cpu_req_i, ADDR_CNT_LO);
  assign hi_rd   = cpu_req_i.rd && hit(cpu_req_i, ADDR_CNT_HI);
  assign lo_rise = lo_rd && !lo_ff;
  assign hi_fall = !hi_rd && hi_ff;

  // Capture edge qualified by the edge field
  always_comb begin
    case (mode_ff.edge_sel)
      EDGE_RISE: cap_edge = capture_pin_i && !pin_ff;
      EDGE_FALL: cap_edge = !capture_pin_i && pin_ff;
      EDGE_BOTH: cap_edge = capture_pin_i != pin_ff;
      default:   cap_edge = 1'b0;
    endcase
  end

  // Inversion enabled by software inside the interrupt window
  assign toggle_rise = cpu_req_i.wr && hit(cpu_req_i, ADDR_MODE)
                       && cpu_req_i.wdata[3] && !mode_ff.toggle_enable;

  // ----------------------------------------------------------------
  // Next state: counter, compare, capture, mode, window, read buffer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_div    = div_ff + 5'h01;
    // Runs on every tick, wrapping from CNT_TOP back to zero
    nxt_cnt    = tick ? cnt_ff + 16'h0001 : cnt_ff;
    nxt_cmp    = cmp_ff;
    nxt_cap    = cap_edge ? cnt_ff : cap_ff;
    nxt_mode   = mode_ff;
    nxt_win    = (win_ff != 5'h00) ? win_ff - 5'h01 : 5'h00;
    nxt_frozen = frozen_ff;
    nxt_buf    = frozen_ff ? buf_ff : cnt_ff;
    nxt_pin    = capture_pin_i;
    nxt_lo     = lo_rd;
    nxt_hi     = hi_rd;
    nxt_rdata  = rdata_ff;

    // Byte writes; each compare byte lands alone, so order matters to software
    if (cpu_req_i.wr) begin
      if (hit(cpu_req_i, ADDR_CMP_LO)) nxt_cmp[7:0]  = cpu_req_i.wdata;
      if (hit(cpu_req_i, ADDR_CMP_HI)) nxt_cmp[15:8] = cpu_req_i.wdata;
      if (hit(cpu_req_i, ADDR_MODE)) begin
        nxt_mode.overflow_flag = cpu_req_i.wdata[6];
        nxt_mode.edge_sel      = cpu_req_i.wdata[5:4];
        nxt_mode.toggle_enable = cpu_req_i.wdata[3];
        nxt_mode.clk_sel       = cpu_req_i.wdata[2:1];
        nxt_mode.output_enable = cpu_req_i.wdata[0];
      end
    end

    // Hardware set wins over a software clear in the same cycle
    if (wrap) nxt_mode.overflow_flag = 1'b1;

    // Interrupt window lasts half a count clock when divided, one cycle on the main clock
    if (match) begin
      nxt_win = (mode_ff.clk_sel == CLK_DIRECT) ? HALF_FAST : HALF_DIV;
    end

    // Output inversion on match, or when enabled during the window
    if ((match && mode_ff.toggle_enable) || (toggle_rise && win_ff != 5'h00)) begin
      nxt_mode.output_level = !mode_ff.output_level;
    end

    // Freeze after low-byte read starts, release after high-byte read ends
    if (lo_rise) nxt_frozen = 1'b1;
    else if (hi_fall) nxt_frozen = 1'b0;

    // Registered read data; an unread address returns zero.
    // The low byte takes the value being frozen, so it pairs with the high byte
    if (cpu_req_i.rd) begin
      case (cpu_req_i.addr)
        ADDR_CNT_LO: nxt_rdata = nxt_buf[7:0];
        ADDR_CNT_HI: nxt_rdata = buf_ff[15:8];
        ADDR_CAP_LO: nxt_rdata = cap_ff[7:0];
        ADDR_CAP_HI: nxt_rdata = cap_ff[15:8];
        ADDR_CMP_LO: nxt_rdata = cmp_ff[7:0];
        ADDR_CMP_HI: nxt_rdata = cmp_ff[15:8];
        ADDR_MODE:   nxt_rdata = mode_ff;
        default:     nxt_rdata = 8'h00;
      endcase
    end
  end

  // Register all state
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_ff    <= CNT_RESET;
      cmp_ff    <= CMP_RESET;
      cap_ff    <= CAP_RESET;
      buf_ff    <= CNT_RESET;
      mode_ff   <= MODE_RESET;
      div_ff    <= 5'h00;
      win_ff    <= 5'h00;
      frozen_ff <= 1'b0;
      pin_ff    <= 1'b0;
      lo_ff     <= 1'b0;
      hi_ff     <= 1'b0;
      rdata_ff  <= 8'h00;
    end else begin
      cnt_ff    <= nxt_cnt;
      cmp_ff    <= nxt_cmp;
      cap_ff    <= nxt_cap;
      buf_ff    <= nxt_buf;
      mode_ff   <= nxt_mode;
      div_ff    <= nxt_div;
      win_ff    <= nxt_win;
      frozen_ff <= nxt_frozen;
      pin_ff    <= nxt_pin;
      lo_ff     <= nxt_lo;
      hi_ff     <= nxt_hi;
      rdata_ff  <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pin latch and direction live in the port block, outside this timer
  assign rdata_o          = rdata_ff;
  assign timer_out_o      = mode_ff.output_level;
  assign timer_out_oe_n_o = !mode_ff.output_enable;
  assign match_irq_o      = win_ff != 5'h00;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  cnt_reset_a: assert property (@(posedge clk_i) !reset_n_i |=> cnt_ff == 16'h0000)
    else $error("counter not cleared by reset");
  cmp_reset_a: assert property (@(posedge clk_i) !reset_n_i |=> cmp_ff == 16'hffff)
    else $error("compare not all ones after reset");
  free_count_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    match |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("counter cleared on match");
  irq_match_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    match |=> match_irq_o)
    else $error("no interrupt after match");
  irq_half_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    match && mode_ff.clk_sel == CLK_DIV32 |=> match_irq_o[*8] ##1 match_irq_o[*8] ##1 !match_irq_o)
    else $error("interrupt window not sixteen cycles");
  toggle_out_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    match && mode_ff.toggle_enable |=> timer_out_o != $past(timer_out_o))
    else $error("output not inverted on match");
  div_rate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tick && mode_ff.clk_sel == CLK_DIV32 |=> !tick[*8])
    else $error("divided count clock too fast");
  cap_load_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cap_edge |-> ##[1:2] cap_ff == $past(cnt_ff))
    else $error("capture missed counter value");
  cap_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mode_ff.edge_sel == EDGE_OFF |=> $stable(cap_ff))
    else $error("capture while disabled");
  freeze_buf_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    lo_rise |=> frozen_ff ##1 buf_ff == $past(buf_ff))
    else $error("read buffer not frozen");
  release_buf_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hi_fall && !lo_rise |=> !frozen_ff)
    else $error("read buffer not released");
  ovf_flag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wrap |=> mode_ff.overflow_flag)
    else $error("overflow flag not set");

endmodule

// ---- tb/test_free_running_timer.sv ----
/*
  Self-checking bench for the free-running timer: byte reads and writes
  on the CPU port, capture pin stimulus, checks of count, compare,
  capture and interrupt behaviour.
  Assumes frt_pkg is compiled first; one clock and a synchronous reset.
*/
`timescale 1ns/1ns
module test_free_running_timer;
  import frt_pkg::*;

  logic        clk_i     = 1'b0;
  logic        reset_n_i = 1'b0;
  cpu_req_t    req       = '0;
  logic        pin       = 1'b0;
  logic [7:0]  rdata_o;
  logic        timer_out_o;
  logic        timer_out_oe_n_o;
  logic        match_irq_o;
  int          err_count    = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  int          t0;

  // ----------------------------------------------------------------
  // Clock, cycle counter and design
  // ----------------------------------------------------------------
  // 125 MHz main clock
  always #4 clk_i = ~clk_i;
  // Bench time base; nonblocking so every task reads the same value
  always @(negedge clk_i) cyc <= cyc + 1;

  free_running_timer free_running_timer_i (
    .clk_i            (clk_i),
    .reset_n_i        (reset_n_i),
    .cpu_req_i        (req),
    .rdata_o          (rdata_o),
    .capture_pin_i    (pin),
    .timer_out_o      (timer_out_o),
    .timer_out_oe_n_o (timer_out_oe_n_o),
    .match_irq_o      (match_irq_o)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Strobe drops between accesses so each read gives the buffer an edge
  task automatic rd8(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_i);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge clk_i);
    req.rd = 1'b0;
    d = rdata_o;
  endtask

  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge clk_i);
    req.wr = 1'b0;
  endtask

  task automatic rd16(input logic [15:0] a, output logic [15:0] v);
    rd8(a, v[7:0]);
    rd8(a + 16'h0001, v[15:8]);
  endtask

  // Waits for the interrupt, stamps its start in t0, measures its width
  task automatic wait_irq(input int limit, output int width);
    int n;
    n = 0;
    width = 0;
    while (match_irq_o !== 1'b1 && n < limit) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= limit) chk(16'h0000, 16'h0001, "interrupt never came");
    t0 = cyc;
    while (match_irq_o === 1'b1 && width < 64) begin
      @(negedge clk_i);
      width++;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog: the full sequence needs about 68000 cycles
  // ----------------------------------------------------------------
  initial begin
    #(8 * 90000);
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    automatic logic [15:0] va;
    automatic logic [15:0] vb;
    automatic logic [15:0] vlast = '0;
    automatic logic [7:0]  b;
    automatic int          w;
    automatic int          t1;
    automatic int          tp;
    automatic int          tlast = 0;
    automatic bit          have = 1'b0;
    automatic int          modes[4] = '{3, 1, 2, 0};
    repeat (16) @(negedge clk_i);
    chk({13'h0, timer_out_o, timer_out_oe_n_o, match_irq_o}, 16'h0002, "reset pins");
    reset_n_i = 1'b1;
    rd16(ADDR_CMP_LO, va);
    chk(va, 16'hffff, "compare reset");
    rd8(ADDR_MODE, b);
    chk(16'(b), 16'h0000, "mode reset");
    rd8(16'hff00, b);
    chk(16'(b), 16'h0000, "unmapped read");
    rd16(ADDR_CNT_LO, va);
    chk(16'(va[15:6]), 16'h0000, "counter restarts from zero");
    // Long gap inside a pair: a live high byte would break the difference
    t0 = cyc;
    rd8(ADDR_CNT_LO, va[7:0]);
    repeat (300) @(negedge clk_i);
    rd8(ADDR_CNT_HI, va[15:8]);
    t1 = cyc;
    rd16(ADDR_CNT_LO, vb);
    chk(vb - va, 16'(t1 - t0), "coherent counter pair");
    // Compare at 0400, toggling output, main clock
    wr8(ADDR_CMP_HI, 8'h04);
    wr8(ADDR_CMP_LO, 8'h00);
    rd16(ADDR_CMP_LO, va);
    chk(va, 16'h0400, "compare readback");
    wr8(ADDR_MODE, 8'h09);
    wait_irq(2000, w);
    t1 = t0;
    chk(16'(w), 16'h0001, "irq width at main clock");
    chk({14'h0, timer_out_o, timer_out_oe_n_o}, 16'h0002, "output toggled high");
    rd16(ADDR_CNT_LO, va);
    chk(16'(va[15:8]), 16'h0004, "counter kept running");
    wait_irq(70000, w);
    chk(16'(t0 - t1), 16'h0000, "one full wrap between matches");
    chk(16'((t0 - t1) >> 16), 16'h0001, "wrap length upper part");
    chk(16'(timer_out_o), 16'h0000, "output toggled low");
    rd8(ADDR_MODE, b);
    chk(16'(b), 16'h0049, "overflow flag set");
    wr8(ADDR_MODE, 8'h09);
    rd8(ADDR_MODE, b);
    chk(16'(b), 16'h0009, "overflow flag cleared");
    // Every capture edge mode, rise then fall of the pin
    foreach (modes[m]) begin
      wr8(ADDR_MODE, {2'b00, 2'(modes[m]), 4'h0});
      for (int ph = 1; ph >= 0; ph--) begin
        @(negedge clk_i);
        pin = ph[0];
        tp = cyc;
        repeat (20) @(negedge clk_i);
        // Pin stays still while the capture register is read
        rd16(ADDR_CAP_LO, va);
        if (modes[m][1 - ph]) begin
          if (have) chk(va, vlast + 16'(tp - tlast), "captured count");
          have = 1'b1;
          vlast = va;
          tlast = tp;
        end else if (have) begin
          chk(va, vlast, "capture held");
        end
      end
    end
    // Divided count clock: 320 cycles give exactly ten counts
    wr8(ADDR_MODE, 8'h02);
    chk(16'(timer_out_oe_n_o), 16'h0001, "output released");
    rd16(ADDR_CNT_LO, va);
    repeat (316) @(negedge clk_i);
    rd16(ADDR_CNT_LO, vb);
    chk(vb - va, 16'h000a, "divided count rate");
    va = vb + 16'h0004;
    wr8(ADDR_CMP_HI, va[15:8]);
    wr8(ADDR_CMP_LO, va[7:0]);
    wait_irq(400, w);
    chk(16'(w), 16'h0010, "irq width at divided clock");
    end_sim();
  end
endmodule
